// ---- rtl/isr_map.svh ----
// register offsets, field positions, reset values and bit positions of the status block
// assumes inclusion by the single design file, the checker and the bench, by bare name
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

// register offsets on the plain register port (word index = address)
`define ISR_A_STB       5'h00
`define ISR_A_SRE       5'h01
`define ISR_A_ESR       5'h02
`define ISR_A_ESE       5'h03
`define ISR_A_QCOND     5'h04
`define ISR_A_QEVT      5'h05
`define ISR_A_QEN       5'h06
`define ISR_A_QPTR      5'h07
`define ISR_A_QNTR      5'h08
`define ISR_A_OCOND     5'h09
`define ISR_A_OEVT      5'h0a
`define ISR_A_OEN       5'h0b
`define ISR_A_OPTR      5'h0c
`define ISR_A_ONTR      5'h0d
`define ISR_A_CTRL      5'h0e
`define ISR_A_CMD       5'h0f
`define ISR_A_CALVAL    5'h10

// command codes written to the command register
`define ISR_CMD_CLS     8'h01
`define ISR_CMD_PRESET  8'h02
`define ISR_CMD_RST     8'h03

// status byte bit positions
`define ISR_STB_QUES    3
`define ISR_STB_ESB     5
`define ISR_STB_RQS     6
`define ISR_STB_OPER    7

// standard event bit positions
`define ISR_ESR_CMDERR  5

// questionable bit positions
`define ISR_Q_TIME      2
`define ISR_Q_FREQ      5
`define ISR_Q_CALERR    8
`define ISR_Q_OOL       10
`define ISR_Q_CMDWARN   14
`define ISR_Q_TOP       15

// operation bit positions
`define ISR_O_MEAS      4

// control register fields
`define ISR_CTRL_AUTOCAL 0

// reset values
`define ISR_RST_AUTOCAL 1'b1
`define ISR_RST_ZERO16  16'h0000
`define ISR_RST_ZERO8   8'h00
// preset: positive filters ones in bits 14 to 0, negative zero, enables zero
`define ISR_RST_PTR     16'h7fff

// event-type questionable bits bypass the transition filters
`define ISR_Q_EVT_MASK  16'h4500

`endif

// ---- rtl/isr_pkg.sv ----
// types shared by the status reporting block and its bench
// assumes nothing beyond a SystemVerilog compiler
package isr_pkg;

    // one register port request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } isr_req_t;

    // events reported by the measurement and parser logic
    typedef struct packed {
        logic cmd_error;
        logic cal_error;
        logic out_of_limit;
        logic cmd_warning;
        logic measuring;
    } isr_evt_t;

    // calibration sequencer states
    typedef enum logic [1:0] {
        ISR_CAL_IDLE,
        ISR_CAL_RUN,
        ISR_CAL_MEAS
    } isr_cal_t;

endpackage

// ---- rtl/isr_status.sv ----
// status reporting block: status byte, standard event, questionable and operation groups
// assumes one 125 MHz clock, synchronous event inputs, plain register port with
// read data in the cycle after the read strobe
// assumes the parser pulses cmd_error once per bad command and the measurement
// engine holds measuring high for the whole of a measurement
// no interrupt of its own: the service request level is the only alert
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "isr_map.svh"

module isr_status #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire isr_pkg::isr_req_t req,
    output logic [15:0] rdata,
    input wire isr_pkg::isr_evt_t evt,
    input wire logic meas_start,
    input wire logic cal_done,
    input wire logic [15:0] cal_result,
    output logic cal_start,
    output logic meas_go,
    output logic [15:0] cal_value,
    output logic srq
);

    // questionable and operation groups share one structure, indexed 0 and 1
    // index 0 is the questionable group, index 1 the operation group
    // live condition bits and their value one cycle back, for edge detection
    logic [W-1:0] cond_r [2];
    logic [W-1:0] cond_prev_r [2];

    // latched events and the software masks that shape them
    logic [W-1:0] evt_r [2];
    logic [W-1:0] en_r [2];
    logic [W-1:0] ptr_r [2];
    logic [W-1:0] ntr_r [2];

    // event-type inputs that skip the filters, and the next event word
    logic [W-1:0] direct [2];
    logic [W-1:0] evt_nxt [2];
    logic [1:0] summ;

    // standard event group and the status byte
    logic [7:0] esr_r;
    logic [7:0] ese_r;
    logic [7:0] sre_r;
    logic [7:0] stb;

    // auto calibration enable and its delayed copy
    logic autocal_r;
    logic autocal_prev_r;

    // one-cycle command strobes decoded from the command register
    logic cls;
    logic preset;
    logic rst_cmd;
    logic wr_cmd;

    // read path and calibration sequencer
    logic [15:0] rdata_nxt;
    isr_pkg::isr_cal_t cal_st_r;

    // command register decode: one-cycle actions
    // an unknown code does nothing; the command word itself reads zero
    assign wr_cmd = req.wr && (req.addr == `ISR_A_CMD);
    assign cls = wr_cmd && (req.wdata[7:0] == `ISR_CMD_CLS);
    assign preset = wr_cmd && (req.wdata[7:0] == `ISR_CMD_PRESET);
    assign rst_cmd = wr_cmd && (req.wdata[7:0] == `ISR_CMD_RST);

    // auto calibration enable, on after reset and after the reset command
    // only bit 0 of the control word counts; filters need preset, not reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            autocal_r <= `ISR_RST_AUTOCAL;
        end else if (rst_cmd) begin
            autocal_r <= `ISR_RST_AUTOCAL;
        end else if (req.wr && req.addr == `ISR_A_CTRL) begin
            autocal_r <= req.wdata[`ISR_CTRL_AUTOCAL];
        end
    end

    // calibration sequencer: calibrate then measure, or measure straight away
    // a request while calibrating is ignored; the engine asks only once
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cal_st_r <= isr_pkg::ISR_CAL_IDLE;
            cal_start <= 1'b0;
            meas_go <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            meas_go <= 1'b0;
            case (cal_st_r)
                // calibrate first when enabled, else start at once
                isr_pkg::ISR_CAL_IDLE: begin
                    if (meas_start && autocal_r) begin
                        cal_start <= 1'b1;
                        cal_st_r <= isr_pkg::ISR_CAL_RUN;
                    end else if (meas_start) begin
                        meas_go <= 1'b1;
                    end
                end
                // no timeout: a lost done from the engine stalls here
                isr_pkg::ISR_CAL_RUN: begin
                    if (cal_done) begin
                        cal_st_r <= isr_pkg::ISR_CAL_MEAS;
                    end
                end
                // one cycle of go once the new values are in place
                isr_pkg::ISR_CAL_MEAS: begin
                    meas_go <= 1'b1;
                    cal_st_r <= isr_pkg::ISR_CAL_IDLE;
                end
                // unused encoding falls back to idle
                default: begin
                    cal_st_r <= isr_pkg::ISR_CAL_IDLE;
                end
            endcase
        end
    end

    // calibration values only replaced by a finished calibration
    // a skipped calibration leaves the previous values in use
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cal_value <= `ISR_RST_ZERO16;
        end else if (cal_st_r == isr_pkg::ISR_CAL_RUN && cal_done) begin
            cal_value <= cal_result;
        end
    end

    // condition registers; a one-cycle lag on calibration keeps edges aligned
    // the delayed copy also resets to on, so no false edge follows reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            autocal_prev_r <= `ISR_RST_AUTOCAL;
        end else begin
            autocal_prev_r <= autocal_r;
        end
    end

    // live condition and direct event words per group
    // unused bits stay zero so the filters never see them
    always_comb begin
        cond_r[0] = '0;
        cond_r[0][`ISR_Q_TIME] = ~autocal_prev_r;
        cond_r[0][`ISR_Q_FREQ] = ~autocal_prev_r;
        cond_r[1] = '0;
        cond_r[1][`ISR_O_MEAS] = evt.measuring;
        direct[0] = '0;
        direct[0][`ISR_Q_CALERR] = evt.cal_error;
        direct[0][`ISR_Q_OOL] = evt.out_of_limit;
        direct[0][`ISR_Q_CMDWARN] = evt.cmd_warning;
        direct[1] = '0;
    end

    // per group: transition filters, event latch, enable, summary
    // one loop keeps both groups identical, so a fix lands in both
    for (genvar g = 0; g < 2; g++) begin : grp
        // edge masks, the surviving event word and the clear strobe
        logic [W-1:0] rise;
        logic [W-1:0] fall;
        logic [W-1:0] keep;
        logic clr_rd;
        // register addresses of this group
        logic [4:0] a_evt;
        logic [4:0] a_en;
        logic [4:0] a_ptr;
        logic [4:0] a_ntr;

        assign a_evt = (g == 0) ? `ISR_A_QEVT : `ISR_A_OEVT;
        assign a_en = (g == 0) ? `ISR_A_QEN : `ISR_A_OEN;
        assign a_ptr = (g == 0) ? `ISR_A_QPTR : `ISR_A_OPTR;
        assign a_ntr = (g == 0) ? `ISR_A_QNTR : `ISR_A_ONTR;

        // transition filters act only on condition bits
        assign rise = cond_r[g] & ~cond_prev_r[g] & ptr_r[g];
        assign fall = ~cond_r[g] & cond_prev_r[g] & ntr_r[g];
        // reading the event register clears it, but a new event still wins
        assign clr_rd = (req.rd && req.addr == a_evt) || cls;
        assign keep = clr_rd ? '0 : evt_r[g];
        // event-type bits bypass the filters, the rest pass only through them
        assign evt_nxt[g] = (keep | rise | fall | direct[g]) & ~`ISR_Q_EVT_MASK
            | ((keep | direct[g]) & `ISR_Q_EVT_MASK);

        // event latch; bit 15 is never stored
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                cond_prev_r[g] <= '0;
                evt_r[g] <= '0;
            end else begin
                cond_prev_r[g] <= cond_r[g];
                evt_r[g] <= evt_nxt[g] & ~(W'(1) << `ISR_Q_TOP);
            end
        end

        // filters and enable, preset restores filter defaults
        // writes drop bit 15 so it never takes part in a summary
        // preset outranks a register write in the same cycle
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                en_r[g] <= '0;
                ptr_r[g] <= `ISR_RST_PTR;
                ntr_r[g] <= '0;
            end else if (preset) begin
                en_r[g] <= '0;
                ptr_r[g] <= `ISR_RST_PTR;
                ntr_r[g] <= '0;
            end else if (req.wr) begin
                if (req.addr == a_en) begin
                    en_r[g] <= req.wdata[W-1:0] & `ISR_RST_PTR;
                end
                if (req.addr == a_ptr) begin
                    ptr_r[g] <= req.wdata[W-1:0] & `ISR_RST_PTR;
                end
                if (req.addr == a_ntr) begin
                    ntr_r[g] <= req.wdata[W-1:0] & `ISR_RST_PTR;
                end
            end
        end

        // group summary into the status byte
        assign summ[g] = |(evt_r[g] & en_r[g]);
    end

    // standard event register: command error set wins over clear
    // only the command error flag has a source in this block
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            esr_r <= `ISR_RST_ZERO8;
        end else begin
            // clear first so a set in the same cycle wins
            if ((req.rd && req.addr == `ISR_A_ESR) || cls) begin
                esr_r <= `ISR_RST_ZERO8;
            end
            if (evt.cmd_error) begin
                esr_r[`ISR_ESR_CMDERR] <= 1'b1;
            end
        end
    end

    // standard event and service request enables
    // bit 6 of the request enable is not writable; it is the summary itself
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ese_r <= `ISR_RST_ZERO8;
            sre_r <= `ISR_RST_ZERO8;
        end else if (req.wr) begin
            if (req.addr == `ISR_A_ESE) begin
                ese_r <= req.wdata[7:0];
            end
            if (req.addr == `ISR_A_SRE) begin
                sre_r <= req.wdata[7:0] & ~(8'h01 << `ISR_STB_RQS);
            end
        end
    end

    // status byte built live from the summaries
    // combinational so the request follows an enable write at once
    always_comb begin
        stb = '0;
        stb[`ISR_STB_QUES] = summ[0];
        stb[`ISR_STB_OPER] = summ[1];
        stb[`ISR_STB_ESB] = |(esr_r & ese_r);
        // request bit summarises the other bits under the request enable
        stb[`ISR_STB_RQS] = |(stb & sre_r);
    end

    // level output; stays high until the cause is cleared or disabled
    assign srq = stb[`ISR_STB_RQS];

    // read mux; unmapped addresses read zero
    // the mux follows the address alone; the strobe picks the cycle
    always_comb begin
        rdata_nxt = '0;
        case (req.addr)
            // byte-wide registers sit in the low byte
            `ISR_A_STB: rdata_nxt = {8'h00, stb};
            `ISR_A_SRE: rdata_nxt = {8'h00, sre_r};
            `ISR_A_ESR: rdata_nxt = {8'h00, esr_r};
            `ISR_A_ESE: rdata_nxt = {8'h00, ese_r};
            // questionable group
            `ISR_A_QCOND: rdata_nxt = cond_r[0];
            `ISR_A_QEVT: rdata_nxt = evt_r[0];
            `ISR_A_QEN: rdata_nxt = en_r[0];
            `ISR_A_QPTR: rdata_nxt = ptr_r[0];
            `ISR_A_QNTR: rdata_nxt = ntr_r[0];
            // operation group
            `ISR_A_OCOND: rdata_nxt = cond_r[1];
            `ISR_A_OEVT: rdata_nxt = evt_r[1];
            `ISR_A_OEN: rdata_nxt = en_r[1];
            `ISR_A_OPTR: rdata_nxt = ptr_r[1];
            `ISR_A_ONTR: rdata_nxt = ntr_r[1];
            // control and calibration
            `ISR_A_CTRL: rdata_nxt = {15'h0000, autocal_r};
            `ISR_A_CALVAL: rdata_nxt = cal_value;
            default: rdata_nxt = '0;
        endcase
    end

    // read data held for exactly the cycle after the strobe
    // returning zero between reads keeps stale values off the port
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata <= `ISR_RST_ZERO16;
        end else if (req.rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= `ISR_RST_ZERO16;
        end
    end

endmodule

`default_nettype wire

// ---- sim/isr_meas_model.sv ----
// calibration and measurement engine that faces the status block
// assumes cal_start and meas_go are one-cycle pulses from the block
`timescale 1ns/1ps
`default_nettype none
module isr_meas_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [15:0] res_in,
    input wire logic cal_start,
    input wire logic meas_go,
    output logic cal_done,
    output logic [15:0] cal_result,
    output logic measuring
);
    int cnt;
    int mcnt;
    // result only valid beside done; otherwise the inverse, so stale values never match
    assign cal_result = cal_done ? res_in : ~res_in;
    // prompt or slow calibration answer, then a measurement of fixed length
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            mcnt <= 0;
            cal_done <= 1'b0;
            measuring <= 1'b0;
        end else begin
            cal_done <= (cnt == 1);
            if (cal_start) begin
                cnt <= slow ? 6 : 1;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            if (meas_go) begin
                mcnt <= 12;
            end else if (mcnt != 0) begin
                mcnt <= mcnt - 1;
            end
            measuring <= meas_go || mcnt > 1;
        end
    end
endmodule
`default_nettype wire

// ---- sim/isr_status_properties.sv ----
// port-level checker for the status block
// assumes the register map header and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "isr_map.svh"
module isr_status_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire isr_pkg::isr_req_t req,
    input wire logic [15:0] rdata,
    input wire logic meas_start,
    input wire logic cal_done,
    input wire logic [15:0] cal_result,
    input wire logic cal_start,
    input wire logic meas_go,
    input wire logic [15:0] cal_value,
    input wire logic srq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic autocal_r;
    // shadow of auto calibration enable, seen only through port writes
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            autocal_r <= `ISR_RST_AUTOCAL;
        end else if (req.wr && req.addr == `ISR_A_CTRL) begin
            autocal_r <= req.wdata[`ISR_CTRL_AUTOCAL];
        end else if (req.wr && req.addr == `ISR_A_CMD && req.wdata[7:0] == `ISR_CMD_RST) begin
            autocal_r <= 1'b1;
        end
    end
    rd_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside an answer");
    auto_cal_a: assert property (meas_start && autocal_r |=> cal_start)
        else $error("no calibration before measurement");
    no_cal_a: assert property (meas_start && !autocal_r |=> meas_go && !cal_start)
        else $error("measurement not started directly");
    cal_keep_a: assert property (cal_done |=> cal_value == $past(cal_result))
        else $error("calibration value not captured");
    cal_hold_a: assert property (!$past(cal_done) |-> $stable(cal_value))
        else $error("calibration value changed without result");
    cal_go_a: assert property (cal_done |-> ##[1:3] meas_go)
        else $error("measurement not started after calibration");
    ques_top_a: assert property (req.rd && req.addr >= `ISR_A_QCOND &&
        req.addr <= `ISR_A_QNTR |=> !rdata[15]) else $error("questionable bit 15 set");
    time_freq_a: assert property (req.rd && req.addr == `ISR_A_QCOND &&
        autocal_r == $past(autocal_r) |=> rdata[2] == !$past(autocal_r, 2)
        && rdata[5] == !$past(autocal_r, 2)) else $error("time or frequency condition wrong");
    rqs_bit_a: assert property (req.rd && req.addr == `ISR_A_STB |=>
        rdata[6] == $past(srq)) else $error("request bit differs from service request");
    cal_pulse_a: assert property (cal_start |=> !cal_start)
        else $error("calibration start longer than one cycle");
endmodule
bind isr_status isr_status_checker i_chk (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata),
    .meas_start(meas_start), .cal_done(cal_done), .cal_result(cal_result),
    .cal_start(cal_start), .meas_go(meas_go), .cal_value(cal_value), .srq(srq));
`default_nettype wire

// ---- sim/isr_status_tb_top.sv ----
// self-checking bench for the status block
// assumes the register map header; the model plays the measurement engine
`timescale 1ns/1ps
`default_nettype none
`include "isr_map.svh"
module isr_status_tb_top;
    logic mclk, reset, meas_start, cal_done, cal_start, meas_go, srq, slow, meas_lvl, rd_d;
    logic [3:0] ev;
    logic [15:0] rdata, cal_result, cal_value, res_in, nr, last;
    isr_pkg::isr_req_t req;
    isr_pkg::isr_evt_t evt;
    logic [15:0] q[$];
    int seed, checked, mismatches, n;
    logic [4:0] ra[6] = '{`ISR_A_STB, `ISR_A_QPTR, `ISR_A_ONTR, `ISR_A_CTRL, 5'h1f, `ISR_A_QEN};
    logic [15:0] re[6] = '{16'h0000, 16'h7fff, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    assign evt = {ev, meas_lvl};
    isr_status i_isr_status (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata), .evt(evt),
        .meas_start(meas_start), .cal_done(cal_done), .cal_result(cal_result),
        .cal_start(cal_start), .meas_go(meas_go), .cal_value(cal_value), .srq(srq));
    isr_meas_model i_isr_meas_model (.mclk(mclk), .reset(reset), .slow(slow), .res_in(res_in),
        .cal_start(cal_start), .meas_go(meas_go), .cal_done(cal_done),
        .cal_result(cal_result), .measuring(meas_lvl));
    always #4 mclk = ~mclk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
    endtask
    // note the expectation, the monitor compares it one cycle on
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        q.push_back(e);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
    endtask
    task automatic cyc(input int k);
        req <= '0;
        repeat (k) @(posedge mclk);
    endtask
    task automatic pulse(input logic [3:0] e);
        ev <= e;
        req <= '0;
        @(posedge mclk);
        ev <= 4'h0;
    endtask
    task give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_d) chk(rdata, q.pop_front());
        rd_d <= req.rd;
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(8 * 5000);
        mismatches++;
        give_verdict();
    end
    initial begin
        seed = 30471;
        mclk = 0;
        reset = 1;
        rd_d = 0;
        req = '0;
        ev = 4'h0;
        meas_start = 0;
        slow = 0;
        res_in = 16'h0000;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 6; i++) rd(ra[i], re[i]);
        wr(`ISR_A_CMD, {8'h00, `ISR_CMD_RST});
        wr(`ISR_A_CMD, {8'h00, `ISR_CMD_CLS});
        wr(`ISR_A_SRE, 16'h0000);
        wr(`ISR_A_ESE, 16'h0000);
        wr(`ISR_A_CMD, {8'h00, `ISR_CMD_PRESET});
        for (int i = 0; i < 4; i++) begin
            nr = 16'($random(seed));
            wr(`ISR_A_QEN, nr);
            rd(`ISR_A_QEN, {1'b0, nr[14:0]});
        end
        wr(`ISR_A_QEN, 16'h0000);
        $display("reset and setup test done");
        wr(`ISR_A_ESE, 16'h0020);
        wr(`ISR_A_SRE, 16'h0020);
        pulse(4'h8);
        cyc(2);
        chk({15'h0, srq}, 16'h0001);
        rd(`ISR_A_STB, 16'h0060);
        rd(`ISR_A_ESR, 16'h0020);
        rd(`ISR_A_ESR, 16'h0000);
        rd(`ISR_A_STB, 16'h0000);
        cyc(1);
        chk({15'h0, srq}, 16'h0000);
        $display("command error test done");
        wr(`ISR_A_SRE, 16'h0000);
        wr(`ISR_A_ESE, 16'h0000);
        wr(`ISR_A_QPTR, 16'h0064);
        wr(`ISR_A_QNTR, 16'h0000);
        wr(`ISR_A_QEN, 16'h0064);
        wr(`ISR_A_SRE, 16'h0008);
        wr(`ISR_A_CTRL, 16'h0000);
        cyc(4);
        chk({15'h0, srq}, 16'h0001);
        rd(`ISR_A_STB, 16'h0048);
        rd(`ISR_A_QCOND, 16'h0024);
        rd(`ISR_A_QEVT, 16'h0024);
        rd(`ISR_A_STB, 16'h0000);
        wr(`ISR_A_CTRL, 16'h0001);
        cyc(4);
        rd(`ISR_A_QEVT, 16'h0000);
        pulse(4'h7);
        cyc(2);
        rd(`ISR_A_QEVT, 16'h4500);
        $display("questionable test done");
        wr(`ISR_A_CMD, {8'h00, `ISR_CMD_CLS});
        wr(`ISR_A_QEN, 16'h0000);
        wr(`ISR_A_OPTR, 16'h0000);
        wr(`ISR_A_ONTR, 16'h0010);
        wr(`ISR_A_OEN, 16'h0010);
        wr(`ISR_A_SRE, 16'h0080);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(`ISR_A_CTRL, 16'h0000);
            nr = 16'($random(seed));
            if (i < 2) last = nr;
            res_in <= nr;
            slow <= i[0];
            meas_start <= 1'b1;
            req <= '0;
            @(posedge mclk);
            meas_start <= 1'b0;
            n = 0;
            while (!meas_lvl && n < 50) begin
                @(posedge mclk);
                n++;
            end
            cyc(2);
            rd(`ISR_A_OCOND, 16'h0010);
            cyc(1);
            chk({15'h0, srq}, 16'h0000);
            n = 0;
            while (!srq && n < 50) begin
                @(posedge mclk);
                n++;
            end
            chk({15'h0, srq}, 16'h0001);
            rd(`ISR_A_STB, 16'h00c0);
            rd(`ISR_A_OEVT, 16'h0010);
            rd(`ISR_A_CALVAL, last);
            cyc(1);
        end
        wr(`ISR_A_CTRL, 16'h0001);
        cyc(2);
        $display("operation test done");
        give_verdict();
    end
endmodule
`default_nettype wire
